// >>> src/mpsm_regs.svh
// Timing counts, input lane positions and reset levels of the power management block.
`ifndef MPSM_REGS_SVH
`define MPSM_REGS_SVH

// ==========================================================================
// Clock rates and derived counts
// ==========================================================================
`define MPSM_CLK_HZ 125000000
`define MPSM_SUSCLK_HZ 32768
// Phase step of the 32-bit suspend clock accumulator, per system clock.
`define MPSM_SUSCLK_INC (32'((64'(`MPSM_SUSCLK_HZ) << 32) / 64'(`MPSM_CLK_HZ)))
// Least time the standby well needs before the resume reset is released.
`define MPSM_RSM_DELAY_NS 10000
`define MPSM_RSM_DELAY_CYC ((`MPSM_RSM_DELAY_NS * (`MPSM_CLK_HZ / 1000000) + 999) / 1000)
// Least button debounce time and least platform reset pulse.
`define MPSM_DEBOUNCE_US 1000
`define MPSM_DEBOUNCE_CYC (`MPSM_DEBOUNCE_US * (`MPSM_CLK_HZ / 1000000))
`define MPSM_RST_HOLD_US 1000
`define MPSM_RST_HOLD_CYC (`MPSM_RST_HOLD_US * (`MPSM_CLK_HZ / 1000000))

// ==========================================================================
// Synchronised input lanes
// ==========================================================================
`define MPSM_IN_COUNT 9
`define MPSM_IN_POWER_BUTTON_N 0
`define MPSM_IN_RESET_BUTTON_N 1
`define MPSM_IN_PGOOD 2
`define MPSM_IN_WAKE_PCIE 3
`define MPSM_IN_WAKE_GP 4
`define MPSM_IN_BATLOW 5
`define MPSM_IN_INTRUDER 6
`define MPSM_IN_OVERTEMP 7
`define MPSM_IN_UNDERVOLT 8
// Idle level of each lane after reset, and which lanes are debounced.
`define MPSM_IN_RST_VAL 9'h0fb
`define MPSM_IN_DEB_MASK 9'h003

`endif

// >>> src/mpsm_pkg.sv
// Types shared by the power management block.
package mpsm_pkg;
    typedef enum logic [1:0] {
        mpsm_off,
        mpsm_on,
        mpsm_ram,
        mpsm_disk
    } mpsm_state_t;
endpackage

// >>> src/mpsm_in_filter.sv
// Two-flop synchroniser with optional debounce and edge pulses for one input pin.
`timescale 1ns/10ps
module mpsm_in_filter #(
    parameter bit RST_VAL = 1'b1,
    parameter int DEB_CYCLES = 1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic pin_in,
    output logic level_r,
    output logic fall,
    output logic rise
);
    localparam int CW = (DEB_CYCLES > 1) ? $clog2(DEB_CYCLES) : 1;

    generate
        if (DEB_CYCLES < 1) begin : g_bad
            $error("mpsm_in_filter: DEB_CYCLES must be at least 1");
        end
    endgenerate

    logic meta_r;
    logic sync_r;
    logic [CW-1:0] cnt_r;

    // ==========================================================================
    // Synchroniser
    // ==========================================================================
    // Only the second flop reads the first, so no logic sees a metastable value.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end else begin
            meta_r <= pin_in;
            sync_r <= meta_r;
        end
    end

    // ==========================================================================
    // Debounce
    // ==========================================================================
    // The level follows only after the new value has stood for DEB_CYCLES clocks.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_r <= '0;
            level_r <= RST_VAL;
        end else if (sync_r == level_r) begin
            cnt_r <= '0;
        end else if (int'(cnt_r) >= DEB_CYCLES - 1) begin
            cnt_r <= '0;
            level_r <= sync_r;
        end else begin
            cnt_r <= cnt_r + CW'(1);
        end
    end

    // Edges are taken on the settled level, so bounce makes no extra pulses.
    assign fall = level_r & ~sync_r & (DEB_CYCLES == 1 || int'(cnt_r) >= DEB_CYCLES - 1);
    assign rise = ~level_r & sync_r & (DEB_CYCLES == 1 || int'(cnt_r) >= DEB_CYCLES - 1);
endmodule

// >>> src/mpsm_top.sv
// Power and system management sequencer: buttons, sleep states, resets, suspend clock, thermal trip.
//
// Summary of operation
// - Each debounced falling edge of the power button makes one power button event.
// - Power button event wakes from soft-off or suspend, or powers a running system down.
// - Reset button low holds platform reset; its falling edge restarts a full reset pulse.
// - Platform reset follows reset button, power-good, undervoltage, watchdog or software request.
// - Carrier raises power-good when main power is good; startup waits while it is low.
// - Synchronised power-good directly enables the internal power supplies.
// - Suspend-to-RAM indicator is low exactly while in the suspend-to-RAM state.
// - Second indicator is low while in suspend-to-disk or soft-off.
// - A 32.768 kHz suspend clock within 100 ppm is driven out.
// - PCIe wake or general wake falling edges wake the system from suspend.
// - Battery-low assertion moves a running system to soft-off in an orderly way.
// - Carrier pulls intrusion low on tamper; a sticky flag records it.
// - Buffered resume reset copies the internal one; its rise means suspend rails stable.
// - Low carrier over-temperature input raises the over-temperature condition.
// - Thermal-trip output goes low once the processor reports thermal shutdown.
`timescale 1ns/10ps
`include "mpsm_regs.svh"
module mpsm_top #(
    parameter int DEBOUNCE_CYCLES = `MPSM_DEBOUNCE_CYC,
    parameter int RST_HOLD_CYCLES = `MPSM_RST_HOLD_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic power_button_n,
    input wire logic reset_button_n,
    input wire logic main_power_good,
    input wire logic pcie_wake_n_in,
    output logic pcie_wake_n_out,
    output logic pcie_wake_n_oe,
    input wire logic gp_wake_n,
    input wire logic battery_low_n,
    input wire logic intrusion_n,
    input wire logic carrier_overtemp_n,
    input wire logic main_undervoltage,
    input wire logic watchdog_timeout,
    input wire logic soft_reset_req,
    input wire logic sleep_ram_req,
    input wire logic sleep_disk_req,
    input wire logic cpu_shutdown,
    input wire logic intrusion_clear,
    output logic platform_reset_n,
    output logic suspend_ram_n,
    output logic suspend_disk_n,
    output logic resume_reset_internal_n,
    output logic resume_reset_buffered_n,
    output logic suspend_clk,
    output logic cpu_thermal_trip_n,
    output logic internal_supply_en,
    output logic power_button_event,
    output logic wake_event,
    output logic overtemp_alert,
    output logic intrusion_flag
);
    localparam int RSM_CYC = `MPSM_RSM_DELAY_CYC;
    localparam int RSM_W = $clog2(RSM_CYC + 1);
    localparam int HOLD_W = $clog2(RST_HOLD_CYCLES + 1);
    localparam logic [`MPSM_IN_COUNT-1:0] IN_RST = `MPSM_IN_RST_VAL;
    localparam logic [`MPSM_IN_COUNT-1:0] IN_DEB = `MPSM_IN_DEB_MASK;

    generate
        if (RST_HOLD_CYCLES < 1 || DEBOUNCE_CYCLES < 1) begin : g_bad
            $error("mpsm_top: hold and debounce counts must be at least 1");
        end
    endgenerate

    logic [`MPSM_IN_COUNT-1:0] pins;
    logic [`MPSM_IN_COUNT-1:0] lvl;
    logic [`MPSM_IN_COUNT-1:0] fall;
    logic [`MPSM_IN_COUNT-1:0] rise;
    mpsm_pkg::mpsm_state_t state_r;
    logic [RSM_W-1:0] rsm_cnt_r;
    logic [HOLD_W-1:0] hold_cnt_r;
    logic [31:0] phase_r;
    logic pwr_evt;
    logic wake_any;
    logic rst_cause;

    // ==========================================================================
    // Input synchronisers
    // ==========================================================================
    assign pins = {main_undervoltage, carrier_overtemp_n, intrusion_n, battery_low_n, gp_wake_n,
                   pcie_wake_n_in, main_power_good, reset_button_n, power_button_n};

    // Every pin is synchronised; only the two buttons pay the debounce delay.
    generate
        for (genvar i = 0; i < `MPSM_IN_COUNT; i++) begin : g_in
            mpsm_in_filter #(
                .RST_VAL(IN_RST[i]),
                .DEB_CYCLES(IN_DEB[i] ? DEBOUNCE_CYCLES : 1)
            ) u_filt (
                .clk(clk),
                .reset(reset),
                .pin_in(pins[i]),
                .level_r(lvl[i]),
                .fall(fall[i]),
                .rise(rise[i])
            );
        end
    endgenerate

    // Events are edges of the settled levels.
    assign pwr_evt = fall[`MPSM_IN_POWER_BUTTON_N];
    assign wake_any = fall[`MPSM_IN_WAKE_PCIE] | fall[`MPSM_IN_WAKE_GP];

    // ==========================================================================
    // Resume reset
    // ==========================================================================
    // The standby well counts from reset release; the buffered copy trails by one clock.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rsm_cnt_r <= '0;
            resume_reset_internal_n <= 1'b0;
            resume_reset_buffered_n <= 1'b0;
        end else begin
            if (int'(rsm_cnt_r) < RSM_CYC) begin
                rsm_cnt_r <= rsm_cnt_r + RSM_W'(1);
            end
            resume_reset_internal_n <= (int'(rsm_cnt_r) >= RSM_CYC);
            resume_reset_buffered_n <= resume_reset_internal_n;
        end
    end

    // ==========================================================================
    // Sleep state machine
    // ==========================================================================
    // Leaving soft-off needs stable standby rails and good main power.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_r <= mpsm_pkg::mpsm_off;
        end else begin
            case (state_r)
                mpsm_pkg::mpsm_off: begin
                    if (pwr_evt && resume_reset_internal_n && lvl[`MPSM_IN_PGOOD]) begin
                        state_r <= mpsm_pkg::mpsm_on;
                    end
                end
                mpsm_pkg::mpsm_on: begin
                    if (pwr_evt || cpu_shutdown || fall[`MPSM_IN_BATLOW]) begin
                        state_r <= mpsm_pkg::mpsm_off;
                    end else if (sleep_ram_req) begin
                        state_r <= mpsm_pkg::mpsm_ram;
                    end else if (sleep_disk_req) begin
                        state_r <= mpsm_pkg::mpsm_disk;
                    end
                end
                mpsm_pkg::mpsm_ram, mpsm_pkg::mpsm_disk: begin
                    if ((pwr_evt || wake_any) && lvl[`MPSM_IN_PGOOD]) begin
                        state_r <= mpsm_pkg::mpsm_on;
                    end
                end
                default: begin
                    state_r <= mpsm_pkg::mpsm_off;
                end
            endcase
        end
    end

    // ==========================================================================
    // Platform reset
    // ==========================================================================
    // A pulse cause restarts the hold count, so a short request still gives a full pulse.
    assign rst_cause = fall[`MPSM_IN_RESET_BUTTON_N] | fall[`MPSM_IN_PGOOD] | rise[`MPSM_IN_UNDERVOLT] |
                       watchdog_timeout | soft_reset_req;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hold_cnt_r <= '0;
        end else if (rst_cause) begin
            hold_cnt_r <= HOLD_W'(RST_HOLD_CYCLES);
        end else if (hold_cnt_r != '0) begin
            hold_cnt_r <= hold_cnt_r - HOLD_W'(1);
        end
    end

    // Levels keep reset low for as long as they last; software cannot shorten it.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            platform_reset_n <= 1'b0;
        end else begin
            platform_reset_n <= (state_r == mpsm_pkg::mpsm_on) && !rst_cause && (hold_cnt_r == '0) &&
                                lvl[`MPSM_IN_RESET_BUTTON_N] && lvl[`MPSM_IN_PGOOD] &&
                                !lvl[`MPSM_IN_UNDERVOLT];
        end
    end

    // ==========================================================================
    // Indicators and supply enable
    // ==========================================================================
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            suspend_ram_n <= 1'b1;
            suspend_disk_n <= 1'b0;
            internal_supply_en <= 1'b0;
        end else begin
            suspend_ram_n <= (state_r != mpsm_pkg::mpsm_ram);
            suspend_disk_n <= (state_r == mpsm_pkg::mpsm_on) || (state_r == mpsm_pkg::mpsm_ram);
            internal_supply_en <= lvl[`MPSM_IN_PGOOD];
        end
    end

    // ==========================================================================
    // Suspend clock
    // ==========================================================================
    // A fractional accumulator keeps the average rate within about 0.8 ppm, well inside 100 ppm;
    // the cost is up to one system clock of jitter on each edge.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            phase_r <= '0;
            suspend_clk <= 1'b0;
        end else begin
            phase_r <= phase_r + `MPSM_SUSCLK_INC;
            suspend_clk <= phase_r[31];
        end
    end

    // ==========================================================================
    // Events, thermal and intrusion
    // ==========================================================================
    // The module never asserts the shared PCIe wake line itself, it only listens.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            power_button_event <= 1'b0;
            wake_event <= 1'b0;
            overtemp_alert <= 1'b0;
            cpu_thermal_trip_n <= 1'b1;
            pcie_wake_n_out <= 1'b1;
            pcie_wake_n_oe <= 1'b0;
        end else begin
            power_button_event <= pwr_evt;
            wake_event <= wake_any;
            overtemp_alert <= !lvl[`MPSM_IN_OVERTEMP];
            cpu_thermal_trip_n <= !cpu_shutdown;
            pcie_wake_n_out <= 1'b1;
            pcie_wake_n_oe <= 1'b0;
        end
    end

    // Tamper is sticky; a tamper seen in the clearing cycle wins over the clear.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            intrusion_flag <= 1'b0;
        end else if (!lvl[`MPSM_IN_INTRUDER]) begin
            intrusion_flag <= 1'b1;
        end else if (intrusion_clear) begin
            intrusion_flag <= 1'b0;
        end
    end

    // ==========================================================================
    // Assertions
    // ==========================================================================
    sequence pwr_press_s;
        pwr_evt && state_r == mpsm_pkg::mpsm_off && resume_reset_internal_n && lvl[`MPSM_IN_PGOOD];
    endsequence
    sequence rsm_release_s;
        $rose(resume_reset_internal_n);
    endsequence

    pwr_event_a: assert property (@(posedge clk) disable iff (reset)
        pwr_evt |=> power_button_event) else $error("power button event lost");
    pwr_wake_a: assert property (@(posedge clk) disable iff (reset)
        pwr_press_s |=> state_r == mpsm_pkg::mpsm_on ##1 suspend_disk_n) else $error("no power-on");
    rst_button_a: assert property (@(posedge clk) disable iff (reset)
        !lvl[`MPSM_IN_RESET_BUTTON_N] |=> !platform_reset_n) else $error("reset button ignored");
    rst_hold_a: assert property (@(posedge clk) disable iff (reset)
        rst_cause |=> !platform_reset_n [*2]) else $error("reset pulse too short");
    startup_hold_a: assert property (@(posedge clk) disable iff (reset)
        state_r != mpsm_pkg::mpsm_on && !lvl[`MPSM_IN_PGOOD] |=> state_r != mpsm_pkg::mpsm_on)
        else $error("started without power good");
    ram_ind_a: assert property (@(posedge clk) disable iff (reset)
        state_r == mpsm_pkg::mpsm_ram |=> !suspend_ram_n && suspend_disk_n)
        else $error("ram indicator wrong");
    disk_ind_a: assert property (@(posedge clk) disable iff (reset)
        (state_r == mpsm_pkg::mpsm_disk || state_r == mpsm_pkg::mpsm_off) |=> !suspend_disk_n && suspend_ram_n)
        else $error("disk indicator wrong");
    wake_ram_a: assert property (@(posedge clk) disable iff (reset)
        state_r == mpsm_pkg::mpsm_ram && wake_any && lvl[`MPSM_IN_PGOOD] |=> state_r == mpsm_pkg::mpsm_on)
        else $error("wake ignored");
    rsm_buffer_a: assert property (@(posedge clk) disable iff (reset)
        rsm_release_s |=> $rose(resume_reset_buffered_n)) else $error("buffered resume late");
    therm_trip_a: assert property (@(posedge clk) disable iff (reset)
        cpu_shutdown |=> !cpu_thermal_trip_n) else $error("thermal trip missed");
endmodule

// >>> test/mpsm_carrier_model.sv
// Carrier board model: drives the management pins and follows the block's indicators.
`timescale 1ns/10ps
module mpsm_carrier_model (
    input wire logic clk,
    input wire logic [7:0] cmd,
    input wire logic suspend_ram_n,
    input wire logic resume_reset_buffered_n,
    output logic power_button_n,
    output logic reset_button_n,
    output logic main_power_good,
    output logic gp_wake_n,
    output logic pcie_pull,
    output logic battery_low_n,
    output logic intrusion_n,
    output logic carrier_overtemp_n,
    output logic rail_en,
    output logic usb_5v_en
);
    // ====================
    // Pin drivers
    logic [7:0] cmd_r = 8'h00;

    // Board logic answers one clock late; pins move on the clock edge, just after the block samples them.
    always @(posedge clk) begin
        cmd_r <= cmd;
    end

    // Buttons and low-active sensors idle high through their pull-ups; power-good idles low.
    assign power_button_n = !cmd_r[0];
    assign reset_button_n = !cmd_r[1];
    assign main_power_good = cmd_r[2];
    assign gp_wake_n = !cmd_r[3];
    assign pcie_pull = cmd_r[4];
    assign battery_low_n = !cmd_r[5];
    assign intrusion_n = !cmd_r[6];
    assign carrier_overtemp_n = !cmd_r[7];

    // ====================
    // Carrier rails
    // The bulk rail follows the low-active RAM indicator itself; USB standby power waits for resume.
    assign rail_en = suspend_ram_n;
    assign usb_5v_en = resume_reset_buffered_n;
endmodule

// >>> test/tb_top.sv
// Self-checking bench for the power management sequencer.
`timescale 1ns/10ps
module tb_top;
    logic clk;
    logic reset = 1'b1;
    logic [7:0] cmd = 8'h00;
    logic [6:0] req = 7'h00;
    int bad_count = 0;
    int checked = 0;
    int cyc = 0;
    int k;
    logic pbn, rbn, pg, gpn, ppull, bln, itn, otn, wk_in, wk_out, wk_oe;
    logic prst, sram, sdisk, rsi, rsb, sclk, ttn, sup, pbe, wke, ota, itf, rail, usb;
    logic [10:0] obs;

    // ====================
    // Wiring
    // The wake line is open drain with a pull-up: low if either side pulls it.
    assign wk_in = !((wk_oe && !wk_out) || ppull);
    assign obs = {sclk, rsi, ttn, itf, ota, sup, wke, pbe, sdisk, sram, prst};

    mpsm_top #(.DEBOUNCE_CYCLES(4), .RST_HOLD_CYCLES(8)) mpsm_top_i (.clk(clk), .reset(reset),
        .power_button_n(pbn), .reset_button_n(rbn), .main_power_good(pg), .pcie_wake_n_in(wk_in),
        .pcie_wake_n_out(wk_out), .pcie_wake_n_oe(wk_oe), .gp_wake_n(gpn), .battery_low_n(bln),
        .intrusion_n(itn), .carrier_overtemp_n(otn), .main_undervoltage(req[2]),
        .watchdog_timeout(req[0]), .soft_reset_req(req[1]), .sleep_ram_req(req[3]),
        .sleep_disk_req(req[4]), .cpu_shutdown(req[5]), .intrusion_clear(req[6]),
        .platform_reset_n(prst), .suspend_ram_n(sram), .suspend_disk_n(sdisk),
        .resume_reset_internal_n(rsi), .resume_reset_buffered_n(rsb), .suspend_clk(sclk),
        .cpu_thermal_trip_n(ttn), .internal_supply_en(sup), .power_button_event(pbe),
        .wake_event(wke), .overtemp_alert(ota), .intrusion_flag(itf));

    mpsm_carrier_model mpsm_carrier_model_i (.clk(clk), .cmd(cmd), .suspend_ram_n(sram),
        .resume_reset_buffered_n(rsb), .power_button_n(pbn), .reset_button_n(rbn),
        .main_power_good(pg), .gp_wake_n(gpn), .pcie_pull(ppull), .battery_low_n(bln),
        .intrusion_n(itn), .carrier_overtemp_n(otn), .rail_en(rail), .usb_5v_en(usb));

    // ====================
    // Clock and watchdog of the run
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // A hung wait ends the run as a failure.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            test_done();
        end
    end

    // ====================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Bounded wait for one observed output, then a comparison of it.
    task automatic wait_until(input int sel, input logic val, input int lim);
        int i;
        i = 0;
        do begin
            step(1);
            i++;
        end while (obs[sel] !== val && i < lim);
        check(obs[sel], val);
    endtask

    task automatic hits(input int sel, input int n, output int cnt);
        cnt = 0;
        repeat (n) begin
            step(1);
            if (obs[sel] === 1'b1) cnt++;
        end
    endtask

    task automatic press(input int b, input int n);
        @(posedge clk) cmd[b] <= 1'b1;
        repeat (n) @(posedge clk);
        cmd[b] <= 1'b0;
    endtask

    task automatic pulse(input logic [6:0] m);
        @(posedge clk) req <= m;
        @(posedge clk) req <= 7'h00;
    endtask

    task automatic power_up();
        fork
            press(0, 10);
            hits(3, 40, k);
        join
        check(k, 1);
        check(obs[2], 1'b1);
        wait_until(0, 1'b1, 20);
    endtask

    // ====================
    // Scenarios
    task automatic t_reset();
        step(3);
        check(obs[2:0], 3'h2);
        check({rsi, rsb, ttn, wk_oe, wk_out}, 5'h05);
        @(posedge clk) reset <= 1'b0;
        step(1200);
        check(rsi, 1'b0);
        wait_until(9, 1'b1, 80);
        check(rsb, 1'b0);
        step(1);
        check(rsb, 1'b1);
        check(usb, 1'b1);
        $display("test reset done");
    endtask

    task automatic t_power_on();
        fork
            press(0, 20);
            hits(3, 40, k);
        join
        check(k, 1);
        check(obs[2:0], 3'h2);
        @(posedge clk) cmd[2] <= 1'b1;
        wait_until(5, 1'b1, 8);
        fork
            press(0, 2);
            hits(3, 30, k);
        join
        check(k, 0);
        power_up();
        $display("test power_on done");
    endtask

    task automatic t_sleep();
        pulse(7'h18);
        wait_until(1, 1'b0, 6);
        check(rail, 1'b0);
        check(obs[2], 1'b1);
        check(obs[0], 1'b0);
        fork
            press(3, 6);
            hits(4, 20, k);
        join
        check(k, 1);
        wait_until(1, 1'b1, 4);
        wait_until(0, 1'b1, 20);
        pulse(7'h10);
        wait_until(2, 1'b0, 6);
        check(obs[1], 1'b1);
        fork
            press(4, 6);
            hits(4, 20, k);
        join
        check(k, 1);
        wait_until(2, 1'b1, 4);
        wait_until(0, 1'b1, 20);
        // A wake while running still pulses the event but must leave the system on.
        fork
            press(3, 6);
            hits(4, 20, k);
        join
        check(k, 1);
        check(obs[2:0], 3'h7);
        $display("test sleep done");
    endtask

    task automatic t_resets();
        logic [6:0] m [3] = '{7'h01, 7'h02, 7'h04};
        fork
            press(1, 20);
            begin
                wait_until(0, 1'b0, 12);
                step(10);
                check(obs[0], 1'b0);
            end
        join
        wait_until(0, 1'b1, 24);
        foreach (m[i]) begin
            pulse(m[i]);
            wait_until(0, 1'b0, 6);
            step(5);
            check(obs[0], 1'b0);
            wait_until(0, 1'b1, 10);
        end
        $display("test resets done");
    endtask

    task automatic t_faults();
        int t0;
        press(5, 10);
        wait_until(2, 1'b0, 16);
        power_up();
        @(posedge clk) req[5] <= 1'b1;
        wait_until(8, 1'b0, 2);
        wait_until(2, 1'b0, 4);
        @(posedge clk) req[5] <= 1'b0;
        wait_until(8, 1'b1, 3);
        fork
            press(7, 10);
            wait_until(6, 1'b1, 8);
        join
        wait_until(6, 1'b0, 8);
        press(6, 6);
        wait_until(7, 1'b1, 8);
        step(10);
        check(obs[7], 1'b1);
        pulse(7'h40);
        wait_until(7, 1'b0, 4);
        wait_until(10, 1'b0, 4000);
        wait_until(10, 1'b1, 4000);
        t0 = cyc;
        wait_until(10, 1'b0, 4000);
        wait_until(10, 1'b1, 4000);
        check((cyc - t0) inside {3814, 3815}, 1'b1);
        @(posedge clk) cmd[2] <= 1'b0;
        wait_until(0, 1'b0, 6);
        wait_until(5, 1'b0, 6);
        $display("test faults done");
    endtask

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ====================
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        t_reset();
        t_power_on();
        t_sleep();
        t_resets();
        t_faults();
        test_done();
    end
endmodule
